// ===== core/irq_seq_map.svh
// Constants of the interrupt sequencer: vectors and widths.
// Assumes an 11-bit program counter and 4-bit core registers.
`ifndef IRQ_SEQ_MAP_SVH
`define IRQ_SEQ_MAP_SVH
`define PC_W          11
`define NIB_W         4
`define VEC_RESET     11'h000
`define VEC_WAKE      11'h004
`define VEC_SHARED    11'h008
`define SRC_TIMER1    0
`define SRC_TIMER2    1
`define SRC_RTC       2
`define SRC_N         3
`endif

// ===== core/irq_seq_pkg.sv
// Types of the interrupt sequencer.
// Assumes irq_seq_map.svh is on the include path.
`include "irq_seq_map.svh"
package irq_seq_pkg;
  typedef struct packed {
    logic [`PC_W-1:0]  pc;
    logic [`NIB_W-1:0] memory_page_high;
    logic [`NIB_W-1:0] table_data_high;
    logic              carry;
    logic              zero;
  } core_ctx_s;
  typedef enum logic [1:0] {
    EV_NONE,
    EV_RESET,
    EV_WAKE,
    EV_IRQ
  } entry_e;
endpackage

// ===== core/mcu_interrupt_sequencer.sv
// Interrupt acceptance, context save and return for a 4-bit core.
// Assumes the core applies pc_load/ctx_load in the cycle they are high.
// Assumes wake_ready is asynchronous and every other input is on clk_sys.
//
// Operation
// - Fetch 00H after reset, 04H after wake-up, 08H for all three sources.
// - Take interrupt only with flag and global enable set, plus its mask for a timer source.
// - Accept in the same cycle the request flag becomes one.
// - Save pc, page-high, table-high, carry and zero in one entry cycle.
// - Load the vector into pc in the same entry cycle.
// - Save the global enable into its shadow on entry, unless low-speed mode is left in the same cycle.
// - Then force the global enable to zero on entry.
// - Return instruction reloads pc, page-high, table-high, carry, zero from shadows.
// - Return instruction restores the global enable from its shadow, unless wake-up or low-speed exit falls in the same cycle.
// - Flags are not cleared on entry; a set flag re-enters after return.
// - A request in the same cycle as clearing enable may still be accepted.
// - On port wake-up, after clock stabilises, resume at the wake vector.
// - Waking from halt clears global enable and both timer masks.
// - Leaving low-speed mode for normal speed clears the global enable.
`timescale 1ns/10ps
`include "irq_seq_map.svh"
module mcu_interrupt_sequencer (
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic [`SRC_N-1:0]      irq_flag_set,
  input  wire logic [`SRC_N-1:0]      irq_flag_clr,
  input  wire logic                   global_irq_enable_set,
  input  wire logic                   global_irq_enable_clr,
  input  wire logic                   timer1_irq_mask_wr,
  input  wire logic                   timer2_irq_mask_wr,
  input  wire logic                   mask_wdata,
  input  wire irq_seq_pkg::core_ctx_s core_ctx,
  input  wire logic                   return_from_interrupt,
  input  wire logic                   wake_ready,
  input  wire logic                   low_speed_exit,
  output logic                        pc_load,
  output logic [`PC_W-1:0]            pc_vector,
  output logic                        ctx_load,
  output irq_seq_pkg::core_ctx_s      ctx_restore,
  output logic                        global_irq_enable,
  output logic                        timer1_irq_mask,
  output logic                        timer2_irq_mask,
  output logic                        timer1_irq_flag,
  output logic                        timer2_irq_flag,
  output logic                        rtc_irq_flag,
  output logic                        irq_taken
);

  // ----------------------------------------------------------------
  // Request flags
  // ----------------------------------------------------------------
  logic [`SRC_N-1:0] flag_q;
  logic              wake_q1;
  logic              wake_q2;
  logic              wake_seen_q;
  logic              wake_evt;
  logic              take;

  // Flags are set by sources and cleared only by software; set wins.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      flag_q <= (flag_q & ~irq_flag_clr) | irq_flag_set;
    end
  end

  assign timer1_irq_flag = flag_q[`SRC_TIMER1];
  assign timer2_irq_flag = flag_q[`SRC_TIMER2];
  assign rtc_irq_flag    = flag_q[`SRC_RTC];

  // ----------------------------------------------------------------
  // Wake-up synchroniser
  // ----------------------------------------------------------------
  // The second and third stages feed the edge detect; the third stage remembers the last level.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wake_q1     <= 1'b0;
      wake_q2     <= 1'b0;
      wake_seen_q <= 1'b0;
    end else begin
      wake_q1     <= wake_ready;
      wake_q2     <= wake_q1;
      wake_seen_q <= wake_q2;
    end
  end

  assign wake_evt = wake_q2 & ~wake_seen_q;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Timer requests pass through their own mask; the clock request has none.
  function automatic logic [`SRC_N-1:0] masked_requests(input logic [`SRC_N-1:0] flags,
                                                         input logic              mask1,
                                                         input logic              mask2);
    masked_requests              = flags;
    masked_requests[`SRC_TIMER1] = flags[`SRC_TIMER1] & mask1;
    masked_requests[`SRC_TIMER2] = flags[`SRC_TIMER2] & mask2;
  endfunction

  // Maps a redirect event onto the address the core fetches from next.
  function automatic logic [`PC_W-1:0] entry_vector(input irq_seq_pkg::entry_e kind);
    case (kind)
      irq_seq_pkg::EV_RESET: entry_vector = `VEC_RESET;
      irq_seq_pkg::EV_WAKE:  entry_vector = `VEC_WAKE;
      irq_seq_pkg::EV_IRQ:   entry_vector = `VEC_SHARED;
      default:               entry_vector = `VEC_SHARED;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Acceptance
  // ----------------------------------------------------------------
  logic [`SRC_N-1:0] pending;

  assign pending = masked_requests(flag_q, timer1_irq_mask, timer2_irq_mask);

  // Flag registers one cycle after the set input, and acceptance falls in the
  // same cycle the flag becomes one. The enable is sampled as registered, so
  // a clear issued in the same cycle still lets one request through.
  always_comb begin
    take = global_irq_enable
         & (|pending)
         & ~wake_evt
         & ~return_from_interrupt;
  end

  // ----------------------------------------------------------------
  // Enable and masks
  // ----------------------------------------------------------------
  logic enable_shadow_q;

  // Wake-up and the speed switch outrank entry, which outranks return and software.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      global_irq_enable <= 1'b0;
      enable_shadow_q   <= 1'b0;
    end else if (wake_evt || low_speed_exit) begin
      global_irq_enable <= 1'b0;
    end else if (take) begin
      enable_shadow_q   <= global_irq_enable;
      global_irq_enable <= 1'b0;
    end else if (return_from_interrupt) begin
      global_irq_enable <= enable_shadow_q;
    end else if (global_irq_enable_set) begin
      global_irq_enable <= 1'b1;
    end else if (global_irq_enable_clr) begin
      global_irq_enable <= 1'b0;
    end
  end

  // Wake-up clears both masks; software writes each through its own strobe, both in one cycle if both are high.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      timer1_irq_mask <= 1'b0;
      timer2_irq_mask <= 1'b0;
    end else if (wake_evt) begin
      timer1_irq_mask <= 1'b0;
      timer2_irq_mask <= 1'b0;
    end else begin
      if (timer1_irq_mask_wr) begin
        timer1_irq_mask <= mask_wdata;
      end
      if (timer2_irq_mask_wr) begin
        timer2_irq_mask <= mask_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Context shadow and program counter redirection
  // ----------------------------------------------------------------
  irq_seq_pkg::core_ctx_s ctx_shadow_q;
  logic                   rst_pending_q;

  // The shadow moves only on entry, so a return always sees the last saved context.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctx_shadow_q <= '0;
    end else if (take) begin
      ctx_shadow_q <= core_ctx;
    end
  end

  // Held high through reset so the first cycle after release fetches the reset vector.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rst_pending_q <= 1'b1;
    end else begin
      rst_pending_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Redirect decode
  // ----------------------------------------------------------------
  // Reset outranks wake-up, and wake-up outranks an interrupt entry.
  irq_seq_pkg::entry_e entry_kind;

  always_comb begin
    if (rst_pending_q) begin
      entry_kind = irq_seq_pkg::EV_RESET;
    end else if (wake_evt) begin
      entry_kind = irq_seq_pkg::EV_WAKE;
    end else if (take) begin
      entry_kind = irq_seq_pkg::EV_IRQ;
    end else begin
      entry_kind = irq_seq_pkg::EV_NONE;
    end
  end

  // Redirect strobes are combinational; the restored context is held in flops.
  assign pc_load     = (entry_kind != irq_seq_pkg::EV_NONE);
  assign pc_vector   = entry_vector(entry_kind);
  assign ctx_load    = return_from_interrupt & ~rst_pending_q;
  assign ctx_restore = ctx_shadow_q;
  assign irq_taken   = take;

endmodule

// ===== tb/irq_seq_monitor.sv
// Checker for the interrupt sequencer, watching its top-level ports only.
// Assumes irq_seq_map.svh is on the include path and irq_seq_pkg is compiled.
`timescale 1ns/10ps
`include "irq_seq_map.svh"
module irq_seq_monitor (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic [`SRC_N-1:0]      irq_flag_clr,
  input wire irq_seq_pkg::core_ctx_s core_ctx,
  input wire logic                   return_from_interrupt,
  input wire logic                   low_speed_exit,
  input wire logic                   pc_load,
  input wire logic [`PC_W-1:0]       pc_vector,
  input wire logic                   ctx_load,
  input wire irq_seq_pkg::core_ctx_s ctx_restore,
  input wire logic                   global_irq_enable,
  input wire logic                   timer1_irq_mask,
  input wire logic                   timer2_irq_mask,
  input wire logic                   timer1_irq_flag,
  input wire logic                   timer2_irq_flag,
  input wire logic                   rtc_irq_flag,
  input wire logic                   irq_taken
);
  logic seen_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) seen_q <= 1'h0;
    else if (irq_taken) seen_q <= 1'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_shared_vector: assert property (irq_taken |-> pc_load && pc_vector == `VEC_SHARED) else $error("bad vector");
  chk_take_gate: assert property (irq_taken |-> global_irq_enable && (timer1_irq_flag && timer1_irq_mask
    || timer2_irq_flag && timer2_irq_mask || rtc_irq_flag)) else $error("ungated entry");
  chk_accept_next: assert property ($rose(rtc_irq_flag) && global_irq_enable && !return_from_interrupt
    |-> irq_taken) else $error("late entry");
  chk_ctx_saved: assert property (irq_taken |=> ctx_restore == $past(core_ctx)) else $error("bad shadow");
  chk_enable_drop: assert property (irq_taken |=> !global_irq_enable) else $error("enable kept");
  chk_ctx_return: assert property (return_from_interrupt |-> ctx_load) else $error("no restore");
  chk_enable_back: assert property (return_from_interrupt && seen_q |=> global_irq_enable) else $error("no enable");
  chk_flag_kept: assert property (irq_taken && rtc_irq_flag && !irq_flag_clr[2] |=> rtc_irq_flag) else $error("flag lost");
  chk_wake_clears: assert property (pc_load && pc_vector == `VEC_WAKE |-> ##[0:1]
    !(global_irq_enable || timer1_irq_mask || timer2_irq_mask)) else $error("wake kept enables");
  chk_speed_clear: assert property (low_speed_exit |=> !global_irq_enable) else $error("enable kept");
  chk_reset_vector: assert property ($rose(rstn) |-> pc_load && pc_vector == `VEC_RESET) else $error("bad reset vector");
  cover property (irq_taken ##[1:20] return_from_interrupt);
  cover property (pc_load && pc_vector == `VEC_WAKE);
  cover property (irq_taken && timer1_irq_flag);
endmodule
bind mcu_interrupt_sequencer irq_seq_monitor irq_seq_monitor_i (.clk_sys, .rstn, .irq_flag_clr, .core_ctx,
  .return_from_interrupt, .low_speed_exit, .pc_load, .pc_vector, .ctx_load, .ctx_restore, .global_irq_enable,
  .timer1_irq_mask, .timer2_irq_mask, .timer1_irq_flag, .timer2_irq_flag, .rtc_irq_flag, .irq_taken);

// ===== tb/core_model.sv
// Core model: program counter and flags that step each cycle and obey loads.
// Assumes irq_seq_pkg is compiled first.
`timescale 1ns/10ps
module core_model (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   pc_load,
  input wire logic [10:0]            pc_vector,
  input wire logic                   ctx_load,
  input wire irq_seq_pkg::core_ctx_s ctx_restore,
  output irq_seq_pkg::core_ctx_s     core_ctx
);
  always_ff @(posedge clk_sys) begin
    if (!rstn) core_ctx <= 21'h1ABCD5;
    else if (ctx_load) core_ctx <= ctx_restore;
    else if (pc_load) core_ctx.pc <= pc_vector;
    else core_ctx <= {core_ctx.pc + 11'h1, core_ctx.table_data_high, core_ctx.memory_page_high + 4'h1,
      core_ctx.zero, ~core_ctx.carry};
  end
endmodule

// ===== tb/tb.sv
// Testbench of the interrupt sequencer with the core model on its far side.
// Assumes the package, header, model and checker files are compiled first.
`timescale 1ns/10ps
`include "irq_seq_map.svh"
module tb;
  logic clk_sys = 1'h0, rstn = 1'h0, wake_ready = 1'h0, mask_wdata, return_from_interrupt, low_speed_exit;
  logic [2:0] irq_flag_set, irq_flag_clr;
  logic global_irq_enable_set, global_irq_enable_clr, timer1_irq_mask_wr, timer2_irq_mask_wr;
  logic pc_load, ctx_load, global_irq_enable, timer1_irq_mask, timer2_irq_mask;
  logic timer1_irq_flag, timer2_irq_flag, rtc_irq_flag, irq_taken;
  logic [10:0] pc_vector;
  irq_seq_pkg::core_ctx_s core_ctx, ctx_restore, saved;
  int n_errors = 0, checks = 0, cycles = 0;
  mcu_interrupt_sequencer mcu_interrupt_sequencer_i (.clk_sys, .rstn, .irq_flag_set, .irq_flag_clr,
    .global_irq_enable_set, .global_irq_enable_clr, .timer1_irq_mask_wr, .timer2_irq_mask_wr, .mask_wdata,
    .core_ctx, .return_from_interrupt, .wake_ready, .low_speed_exit, .pc_load, .pc_vector, .ctx_load,
    .ctx_restore, .global_irq_enable, .timer1_irq_mask, .timer2_irq_mask, .timer1_irq_flag,
    .timer2_irq_flag, .rtc_irq_flag, .irq_taken);
  core_model core_model_i (.clk_sys, .rstn, .pc_load, .pc_vector, .ctx_load, .ctx_restore, .core_ctx);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 500) begin
      n_errors++;
      finish_test;
    end
  end
  // Drives one cycle of strobes at the falling edge: set, clear, enable, masks, return, speed.
  task automatic go(logic [12:0] p);
    @(negedge clk_sys);
    {irq_flag_set, irq_flag_clr, global_irq_enable_set, global_irq_enable_clr, timer1_irq_mask_wr,
      timer2_irq_mask_wr, mask_wdata, return_from_interrupt, low_speed_exit} = p;
    #1;
  endtask
  task automatic chk(logic [20:0] got, logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    go(13'h0);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1'h1;
    #1;
    chk({pc_load, pc_vector}, 21'h800);
    go(13'h54);
    go(13'h400);
    go(13'h0);
    chk({irq_taken, pc_load, pc_vector, rtc_irq_flag, timer2_irq_flag, timer1_irq_flag}, 21'hC041);
    saved = core_ctx;
    go(13'h0);
    chk(ctx_restore, saved);
    chk({global_irq_enable, timer1_irq_flag, core_ctx.pc}, 21'h808);
    go(13'h2);
    chk({ctx_load, irq_taken}, 21'h2);
    go(13'h0);
    chk(core_ctx, saved);
    chk({global_irq_enable, irq_taken}, 21'h3);
    go(13'h80);
    go(13'h2);
    go(13'h0);
    chk({irq_taken, global_irq_enable, timer1_irq_flag}, 21'h2);
    go(13'h800);
    go(13'h0);
    chk({irq_taken, timer2_irq_flag}, 21'h1);
    go(13'h1100);
    go(13'h20);
    chk(irq_taken, 21'h1);
    go(13'h0);
    go(13'h200);
    go(13'h2);
    go(13'h1);
    go(13'h0);
    chk(global_irq_enable, 21'h0);
    go(13'h5C);
    wake_ready = 1'h1;
    repeat (8) if (!pc_load) go(13'h0);
    chk({pc_load, pc_vector}, 21'h804);
    go(13'h0);
    chk({global_irq_enable, timer1_irq_mask, timer2_irq_mask}, 21'h0);
    go(13'h5C);
    go(13'h800);
    go(13'h0);
    chk({irq_taken, timer2_irq_flag, pc_vector}, 21'h1808);
    finish_test;
  end
endmodule
